// ===== design/triple_timer_defines.vh
// Register map, field positions, reset values and mode codes of the timer unit
`ifndef TRIPLE_TIMER_DEFINES_VH
`define TRIPLE_TIMER_DEFINES_VH

// Register addresses
`define T0_CONTROL_ADDR 5'h00
`define T0_COMPARE_ADDR 5'h01
`define T0_CAPTURE_ADDR 5'h02
`define T0_COUNT_ADDR 5'h03
`define T1_CONTROL_ADDR 5'h04
`define T1_A_LOW_ADDR 5'h05
`define T1_A_HIGH_ADDR 5'h06
`define T1_B_LOW_ADDR 5'h07
`define T1_B_HIGH_ADDR 5'h08
`define T1_COUNT_LOW_ADDR 5'h09
`define T1_COUNT_HIGH_ADDR 5'h0A
`define T2_CONTROL_ADDR 5'h0C
`define T2_A_LOW_ADDR 5'h0D
`define T2_A_HIGH_ADDR 5'h0E
`define T2_B_LOW_ADDR 5'h0F
`define T2_B_HIGH_ADDR 5'h10
`define T2_COUNT_LOW_ADDR 5'h11
`define T2_COUNT_HIGH_ADDR 5'h12
`define PORT1_FSEL_ADDR 5'h14
`define IRQ_FLAGS_ADDR 5'h15

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_CK_LSB 3

// Reset values
`define CTRL_RESET 8'h00
`define DATA_RESET 8'hFF
`define CAPTURE_RESET 8'h00
`define FSEL_RESET 8'h00

// Internal operating codes of one channel
`define OP_COUNT 3'h0
`define OP_PWM 3'h1
`define OP_CAPT 3'h2
`define OP_ONESHOT 3'h3
`define OP_REPEAT 3'h4

`endif

// ===== design/triple_timer_counter_unit.v
// Three timer/counters with prescaler, clock select, capture and pulse outputs
`timescale 1ns/10ps
`include "triple_timer_defines.vh"

module timer_channel #(
  parameter W = 8
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Control
  input wire tick,
  input wire enable,
  input wire [2:0] op,
  input wire [W-1:0] limit,
  input wire [W-1:0] duty,
  // State and pins
  output wire [W-1:0] count,
  output wire match,
  output wire togglePin,
  output wire pwmPin
);
  // Unit step at counter width, so the increment needs no silent padding
  localparam [W-1:0] countStep = {{(W-1){1'b0}}, 1'b1};
  reg [W-1:0] count_q;
  reg done_q;
  reg match_q;
  reg toggle_q;
  reg pwm_q;
  wire atLimit;
  wire pulseOp;

  assign atLimit = (count_q == limit);
  assign pulseOp = (op == `OP_PWM) || (op == `OP_ONESHOT) || (op == `OP_REPEAT);
  assign count = count_q;
  assign match = match_q;
  assign togglePin = toggle_q;
  assign pwmPin = pwm_q;

  // Counter, match pulse and toggle output
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_q <= {W{1'b0}};
      done_q <= 1'b0;
      match_q <= 1'b0;
      toggle_q <= 1'b0;
    end else if (!enable) begin
      count_q <= {W{1'b0}};
      done_q <= 1'b0; // Re-enable arms the one-shot again
      match_q <= 1'b0;
    end else begin
      match_q <= 1'b0;
      if (tick && !done_q) begin
        case (op)
          `OP_COUNT, `OP_ONESHOT, `OP_REPEAT: begin
            if (atLimit) begin
              count_q <= {W{1'b0}};
              match_q <= 1'b1;
              done_q <= (op == `OP_ONESHOT);
              if (op == `OP_COUNT) begin
                toggle_q <= ~toggle_q;
              end
            end else begin
              count_q <= count_q + countStep;
            end
          end
          `OP_PWM: begin
            count_q <= count_q + countStep;
            match_q <= &count_q;
          end
          default: begin
            count_q <= count_q + countStep;
          end
        endcase
      end
    end
  end

  // Pulse output high while count is below the duty value
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= enable && pulseOp && !done_q && (count_q < duty);
    end
  end
endmodule // timer_channel

module triple_timer_counter_unit (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Register port
  input wire [4:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output wire [7:0] rdata,
  // Power state
  input wire idleMode,
  input wire stopMode,
  // External pins
  input wire t0ExternalClockPin,
  input wire t1ExternalClockPin,
  input wire highFreqOscClock,
  input wire extIrqLine0,
  input wire extIrqLine11,
  input wire extIrqLine12,
  // Interrupt service
  input wire [2:0] irqAck,
  output wire [2:0] irqRequest,
  // Output pins
  output wire t0TogglePin,
  output wire t0PwmPin,
  output wire t1ComparePin,
  output wire t1PwmPin,
  output wire t2TogglePin,
  output wire t2PwmPin
);
  reg [7:0] t0Control_q;
  reg [7:0] t0CompareData_q;
  reg [7:0] t0CaptureData_q;
  reg [7:0] t1Control_q;
  reg [15:0] t1AData_q;
  reg [15:0] t1BData_q;
  reg [7:0] t2Control_q;
  reg [15:0] t2AData_q;
  reg [15:0] t2BData_q;
  reg [7:0] port1FunctionSelectLow_q;
  reg [2:0] irqFlags_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg [10:0] presc_q;
  reg [5:0] syncA_q;
  reg [5:0] syncB_q;
  reg [5:0] prev_q;
  wire [5:0] rise;
  wire run;
  wire [7:0] t0Ticks;
  wire [7:0] t1Ticks;
  wire [7:0] t2Ticks;
  wire [2:0] t0Op;
  wire [2:0] t1Op;
  wire [2:0] t2Op;
  wire [7:0] t0Count;
  wire [15:0] t1Count;
  wire [15:0] t2Count;
  wire t0Match;
  wire t1Match;
  wire t2Match;

  // Mode field of a 16-bit timer to channel operation
  function [2:0] op16;
    input [1:0] mode;
    begin
      case (mode)
        2'h0: op16 = `OP_COUNT;
        2'h1: op16 = `OP_CAPT;
        2'h2: op16 = `OP_ONESHOT;
        default: op16 = `OP_REPEAT;
      endcase
    end
  endfunction

  // Two-stage synchronisers and edge detect on outside pins
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
      prev_q <= 6'h00;
    end else begin
      syncA_q <= {extIrqLine12, extIrqLine11, extIrqLine0,
        highFreqOscClock, t1ExternalClockPin, t0ExternalClockPin};
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
    end
  end
  assign rise = syncB_q & ~prev_q;

  // Free-running prescaler, frozen in stop mode; idle leaves it running
  assign run = !stopMode;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      presc_q <= 11'h000;
    end else if (run) begin
      presc_q <= presc_q + 11'h001;
    end
  end

  // Clock-select taps; the two external clock pins and the timer 1 match bypass the stop gating, the fast oscillator input does not
  assign t0Ticks = {rise[0], run & (&presc_q[10:0]), run & (&presc_q[8:0]),
    run & (&presc_q[6:0]), run & (&presc_q[4:0]), run & (&presc_q[2:0]),
    run & (&presc_q[1:0]), run & presc_q[0]};
  assign t1Ticks = {rise[1], run & rise[2], run & (&presc_q[10:0]),
    run & (&presc_q[5:0]), run & (&presc_q[2:0]), run & (&presc_q[1:0]),
    run & presc_q[0], run};
  assign t2Ticks = {t1Match, run & (&presc_q[8:0]), run & (&presc_q[6:0]),
    run & (&presc_q[4:0]), run & (&presc_q[2:0]), run & (&presc_q[1:0]),
    run & presc_q[0], run};

  // Mode decode
  assign t0Op = t0Control_q[`CTRL_MODE_LSB+1] ? `OP_CAPT :
    (t0Control_q[`CTRL_MODE_LSB] ? `OP_PWM : `OP_COUNT);
  assign t1Op = op16(t1Control_q[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB]);
  assign t2Op = op16(t2Control_q[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB]);

  // Timer 0, 8-bit
  timer_channel #(.W(8)) timer0 (
    .clock(clock),
    .nrst(nrst),
    .tick(t0Ticks[t0Control_q[`CTRL_CK_LSB+2:`CTRL_CK_LSB]]),
    .enable(t0Control_q[`CTRL_EN_BIT]),
    .op(t0Op),
    .limit(t0CompareData_q),
    .duty(t0CompareData_q),
    .count(t0Count),
    .match(t0Match),
    .togglePin(t0TogglePin),
    .pwmPin(t0PwmPin)
  );

  // Timer 1, 16-bit
  timer_channel #(.W(16)) timer1 (
    .clock(clock),
    .nrst(nrst),
    .tick(t1Ticks[t1Control_q[`CTRL_CK_LSB+2:`CTRL_CK_LSB]]),
    .enable(t1Control_q[`CTRL_EN_BIT]),
    .op(t1Op),
    .limit(t1AData_q),
    .duty(t1BData_q),
    .count(t1Count),
    .match(t1Match),
    .togglePin(t1ComparePin),
    .pwmPin(t1PwmPin)
  );

  // Timer 2, 16-bit
  timer_channel #(.W(16)) timer2 (
    .clock(clock),
    .nrst(nrst),
    .tick(t2Ticks[t2Control_q[`CTRL_CK_LSB+2:`CTRL_CK_LSB]]),
    .enable(t2Control_q[`CTRL_EN_BIT]),
    .op(t2Op),
    .limit(t2AData_q),
    .duty(t2BData_q),
    .count(t2Count),
    .match(t2Match),
    .togglePin(t2TogglePin),
    .pwmPin(t2PwmPin)
  );

  // Register writes; a capture event wins over a write to the same register
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      t0Control_q <= `CTRL_RESET;
      t0CompareData_q <= `DATA_RESET;
      t0CaptureData_q <= `CAPTURE_RESET;
      t1Control_q <= `CTRL_RESET;
      t1AData_q <= {`DATA_RESET, `DATA_RESET};
      t1BData_q <= {`DATA_RESET, `DATA_RESET};
      t2Control_q <= `CTRL_RESET;
      t2AData_q <= {`DATA_RESET, `DATA_RESET};
      t2BData_q <= {`DATA_RESET, `DATA_RESET};
      port1FunctionSelectLow_q <= `FSEL_RESET;
    end else begin
      if (wr) begin
        case (addr)
          `T0_CONTROL_ADDR: t0Control_q <= wdata;
          `T0_COMPARE_ADDR: t0CompareData_q <= wdata;
          `T1_CONTROL_ADDR: t1Control_q <= wdata;
          `T1_A_LOW_ADDR: t1AData_q[7:0] <= wdata;
          `T1_A_HIGH_ADDR: t1AData_q[15:8] <= wdata;
          `T1_B_LOW_ADDR: t1BData_q[7:0] <= wdata;
          `T1_B_HIGH_ADDR: t1BData_q[15:8] <= wdata;
          `T2_CONTROL_ADDR: t2Control_q <= wdata;
          `T2_A_LOW_ADDR: t2AData_q[7:0] <= wdata;
          `T2_A_HIGH_ADDR: t2AData_q[15:8] <= wdata;
          `T2_B_LOW_ADDR: t2BData_q[7:0] <= wdata;
          `T2_B_HIGH_ADDR: t2BData_q[15:8] <= wdata;
          `PORT1_FSEL_ADDR: port1FunctionSelectLow_q <= wdata;
          default: ;
        endcase
      end
      if (t0Control_q[`CTRL_EN_BIT] && t0Op == `OP_CAPT && rise[3]) begin
        t0CaptureData_q <= t0Count;
      end
      if (t1Control_q[`CTRL_EN_BIT] && t1Op == `OP_CAPT && rise[4]) begin
        t1BData_q <= t1Count;
      end
      if (t2Control_q[`CTRL_EN_BIT] && t2Op == `OP_CAPT && rise[5]) begin
        t2BData_q <= t2Count;
      end
    end
  end

  // Match flags: a new match wins over service in the same cycle
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqFlags_q <= 3'h0;
    end else begin
      irqFlags_q <= (irqFlags_q & ~irqAck) | {t2Match, t1Match, t0Match};
    end
  end
  assign irqRequest = irqFlags_q;

  // Read mux
  always @* begin
    case (addr)
      `T0_CONTROL_ADDR: rdata_d = t0Control_q;
      `T0_COMPARE_ADDR: rdata_d = t0CompareData_q;
      `T0_CAPTURE_ADDR: rdata_d = t0CaptureData_q;
      `T0_COUNT_ADDR: rdata_d = t0Count;
      `T1_CONTROL_ADDR: rdata_d = t1Control_q;
      `T1_A_LOW_ADDR: rdata_d = t1AData_q[7:0];
      `T1_A_HIGH_ADDR: rdata_d = t1AData_q[15:8];
      `T1_B_LOW_ADDR: rdata_d = t1BData_q[7:0];
      `T1_B_HIGH_ADDR: rdata_d = t1BData_q[15:8];
      `T1_COUNT_LOW_ADDR: rdata_d = t1Count[7:0];
      `T1_COUNT_HIGH_ADDR: rdata_d = t1Count[15:8];
      `T2_CONTROL_ADDR: rdata_d = t2Control_q;
      `T2_A_LOW_ADDR: rdata_d = t2AData_q[7:0];
      `T2_A_HIGH_ADDR: rdata_d = t2AData_q[15:8];
      `T2_B_LOW_ADDR: rdata_d = t2BData_q[7:0];
      `T2_B_HIGH_ADDR: rdata_d = t2BData_q[15:8];
      `T2_COUNT_LOW_ADDR: rdata_d = t2Count[7:0];
      `T2_COUNT_HIGH_ADDR: rdata_d = t2Count[15:8];
      `PORT1_FSEL_ADDR: rdata_d = port1FunctionSelectLow_q;
      `IRQ_FLAGS_ADDR: rdata_d = {5'h00, irqFlags_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rdata_d : 8'h00;
    end
  end
  assign rdata = rdata_q;

  // Idle mode needs no action: every clock keeps running
  wire unusedIdle = idleMode;
endmodule // triple_timer_counter_unit

// ===== tb/triple_timer_counter_unit_props.sv
// Port-level property checker for the triple timer unit
`timescale 1ns/10ps
module timer_unit_props (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Register port
  input wire [4:0] addr,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // Power state and pins
  input wire stopMode,
  input wire t0ExternalClockPin,
  input wire t1ExternalClockPin,
  input wire [2:0] irqAck,
  input wire [2:0] irqRequest,
  input wire t0TogglePin,
  input wire t1ComparePin,
  input wire t2TogglePin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Read data stands only after a read
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property ($past(rd) && $past(addr) == 5'h1F |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Flags read back and stay until serviced
  a_flags_read: assert property ($past(rd) && $past(addr) == 5'h15
      |-> rdata == {5'h00, $past(irqRequest)})
    else $error("flag read mismatch");
  a_flag_hold: assert property ((($past(irqRequest) & ~$past(irqAck)) & ~irqRequest) == 3'h0)
    else $error("flag dropped without service");
  // A toggle comes with its match flag
  a_t0_toggle_flag: assert property ($changed(t0TogglePin) |-> ##[0:1] irqRequest[0])
    else $error("timer 0 toggle without match flag");
  a_t1_compare_flag: assert property ($changed(t1ComparePin) |-> ##[0:1] irqRequest[1])
    else $error("timer 1 pin change without match flag");
  a_t2_toggle_flag: assert property ($changed(t2TogglePin) |-> ##[0:1] irqRequest[2])
    else $error("timer 2 toggle without match flag");
  // Stop with quiet pins freezes the outputs
  a_stop_quiet: assert property ((stopMode && !t0ExternalClockPin && !t1ExternalClockPin && !wr)
      [*8] |=> $stable({t0TogglePin, t1ComparePin, t2TogglePin}))
    else $error("output moved during stop");
endmodule // timer_unit_props

bind triple_timer_counter_unit timer_unit_props props (.clock(clock), .nrst(nrst),
  .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .stopMode(stopMode),
  .t0ExternalClockPin(t0ExternalClockPin), .t1ExternalClockPin(t1ExternalClockPin),
  .irqAck(irqAck), .irqRequest(irqRequest), .t0TogglePin(t0TogglePin),
  .t1ComparePin(t1ComparePin), .t2TogglePin(t2TogglePin));

// ===== tb/timer_pin_model.sv
// Model of the external pins facing the timer unit
`timescale 1ns/10ps
module timer_pin_model (
  // Clock
  input wire clock,
  // Pins: clocks 0/1, fast osc, capture lines 0/11/12
  output reg [5:0] pins
);
  initial pins = 6'h00;
  // Clean pulses, three clocks high and four low between pulses, so the synchroniser sees them
  task pulse(input integer idx, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clock);
        pins[idx] <= 1'b1;
        repeat (3) @(posedge clock);
        pins[idx] <= 1'b0;
        repeat (3) @(posedge clock);
      end
    end
  endtask
endmodule // timer_pin_model

// ===== tb/triple_timer_counter_unit_bench.sv
// Self-checking bench for the triple timer unit
`timescale 1ns/10ps
`include "triple_timer_defines.vh"
module triple_timer_counter_unit_bench;
  reg clock = 1'b0;
  reg nrst = 1'b0;
  reg [4:0] addr = 5'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg idleMode = 1'b0;
  reg stopMode = 1'b0;
  reg [2:0] irqAck = 3'h0;
  wire [5:0] pins;
  wire [7:0] rdata;
  wire [2:0] irqRequest;
  wire [2:0] tog;
  wire [2:0] pwm;
  integer fail_count = 0;
  integer comparisons = 0;
  integer n;
  integer t;
  reg [7:0] seen;
  reg [7:0] held;
  reg [4:0] base;
  // Clock of 25 ns
  always #12.5 clock = ~clock;
  timer_pin_model pinModel (.clock(clock), .pins(pins));
  triple_timer_counter_unit dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .idleMode(idleMode), .stopMode(stopMode),
    .t0ExternalClockPin(pins[0]), .t1ExternalClockPin(pins[1]), .highFreqOscClock(pins[2]),
    .extIrqLine0(pins[3]), .extIrqLine11(pins[4]), .extIrqLine12(pins[5]), .irqAck(irqAck),
    .irqRequest(irqRequest), .t0TogglePin(tog[0]), .t0PwmPin(pwm[0]), .t1ComparePin(tog[1]),
    .t1PwmPin(pwm[1]), .t2TogglePin(tog[2]), .t2PwmPin(pwm[2]));
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input [63:0] what, input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wreg(input [4:0] a, input [7:0] d);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [4:0] a);
    begin
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 seen = rdata;
    end
  endtask
  // Bounded wait for a toggle pin to change; c counts edges
  task waitFlip(input integer i, output integer c);
    reg old;
    begin
      old = tog[i];
      c = 0;
      while (tog[i] === old) begin
        @(posedge clock);
        #1 c = c + 1;
        if (c > 5000) begin
          fail_count = fail_count + 1;
          print_verdict;
        end
      end
    end
  endtask
  task countHigh(input integer i, input integer len, output integer c);
    begin
      c = 0;
      repeat (len) begin
        @(posedge clock);
        #1 if (pwm[i] === 1'b1) c = c + 1;
      end
    end
  endtask
  task testRegs;
    begin
      rreg(`T0_CONTROL_ADDR);
      check("ctrl0", seen, 8'h00);
      rreg(`T0_COMPARE_ADDR);
      check("cmp0", seen, 8'hFF);
      rreg(`T1_B_HIGH_ADDR);
      check("b1high", seen, 8'hFF);
      rreg(5'h1F);
      check("unmapped", seen, 8'h00);
      $display("test registers done");
    end
  endtask
  // Counter mode at /2 in idle, compare 2, then service the flag
  task testCounter;
    begin
      @(posedge clock);
      idleMode <= 1'b1;
      wreg(`T0_COMPARE_ADDR, 8'h02);
      wreg(`T0_CONTROL_ADDR, 8'h01);
      waitFlip(0, n);
      waitFlip(0, n);
      check("t0period", n, 6);
      rreg(`IRQ_FLAGS_ADDR);
      check("flag0", seen[0], 1'b1);
      wreg(`T0_CONTROL_ADDR, 8'h00);
      irqAck <= 3'h7;
      @(posedge clock);
      irqAck <= 3'h0;
      idleMode <= 1'b0;
      rreg(`IRQ_FLAGS_ADDR);
      check("flagclr", seen, 8'h00);
      $display("test counter done");
    end
  endtask
  // External clock keeps counting while stopped; fast oscillator clock after wake
  task testExtStop;
    begin
      wreg(`T0_COMPARE_ADDR, 8'hFF);
      wreg(`T0_CONTROL_ADDR, 8'h39);
      stopMode <= 1'b1;
      pinModel.pulse(0, 3);
      repeat (4) @(posedge clock);
      rreg(`T0_COUNT_ADDR);
      check("extcount", seen, 8'h03);
      wreg(`T0_CONTROL_ADDR, 8'h00);
      stopMode <= 1'b0;
      wreg(`T1_CONTROL_ADDR, 8'h31);
      pinModel.pulse(2, 2);
      repeat (4) @(posedge clock);
      rreg(`T1_COUNT_LOW_ADDR);
      check("hfocount", seen, 8'h02);
      wreg(`T1_CONTROL_ADDR, 8'h00);
      $display("test external clock done");
    end
  endtask
  // Capture of a frozen count on each timer
  task testCapture;
    begin
      for (t = 0; t < 3; t = t + 1) begin
        base = (t == 0) ? 5'h00 : ((t == 1) ? 5'h04 : 5'h0C);
        wreg(base, (t == 0) ? 8'h05 : 8'h03);
        repeat (20) @(posedge clock);
        stopMode <= 1'b1;
        repeat (10) @(posedge clock);
        rreg((t == 0) ? `T0_COUNT_ADDR : base + 5'h05);
        held = seen;
        pinModel.pulse(3 + t, 1);
        repeat (6) @(posedge clock);
        rreg((t == 0) ? `T0_CAPTURE_ADDR : base + 5'h03);
        check("capture", seen, held);
        wreg(base, 8'h00);
        stopMode <= 1'b0;
      end
      $display("test capture done");
    end
  endtask
  // Timer 0 PWM: compare 0x80 gives 128 high ticks of 256 at /2
  task testPwm0;
    begin
      wreg(`T0_COMPARE_ADDR, 8'h80);
      wreg(`T0_CONTROL_ADDR, 8'h03);
      repeat (6) @(posedge clock);
      countHigh(0, 512, n);
      check("pwm0", n, 256);
      wreg(`T0_CONTROL_ADDR, 8'h00);
      $display("test pwm done");
    end
  endtask
  // Repeat and one-shot pulses, period A+1 = 4, width B = 1
  task testPulse;
    begin
      wreg(`PORT1_FSEL_ADDR, 8'h3C);
      for (t = 1; t < 3; t = t + 1) begin
        base = (t == 1) ? `T1_A_LOW_ADDR : `T2_A_LOW_ADDR;
        wreg(base, 8'h03);
        wreg(base + 5'h01, 8'h00);
        wreg(base + 5'h02, 8'h01);
        wreg(base + 5'h03, 8'h00);
        wreg(base - 5'h01, 8'h07);
        repeat (8) @(posedge clock);
        countHigh(t, 40, n);
        check("repeat", n, 10);
        wreg(base - 5'h01, 8'h00);
        wreg(base - 5'h01, 8'h05);
        countHigh(t, 40, n);
        check("oneshot", n, 1);
        wreg(base - 5'h01, 8'h00);
      end
      $display("test pulse done");
    end
  endtask
  // Timer 1 counter mode at /1 clocks timer 2 through its A match
  task testChain;
    begin
      wreg(`T1_A_LOW_ADDR, 8'h01);
      wreg(`T2_A_LOW_ADDR, 8'h02);
      wreg(`T2_CONTROL_ADDR, 8'h39);
      wreg(`T1_CONTROL_ADDR, 8'h01);
      waitFlip(1, n);
      waitFlip(1, n);
      check("t1period", n, 2);
      waitFlip(2, n);
      waitFlip(2, n);
      check("t2period", n, 6);
      check("irqpins", irqRequest[2:1], 2'h3);
      wreg(`T2_CONTROL_ADDR, 8'h00);
      wreg(`T1_CONTROL_ADDR, 8'h00);
      repeat (3) @(posedge clock);
      irqAck <= 3'h7;
      @(posedge clock);
      irqAck <= 3'h0;
      @(posedge clock);
      #1 check("irqclear", irqRequest, 3'h0);
      $display("test chain done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    testRegs;
    testCounter;
    testExtStop;
    testCapture;
    testPwm0;
    testPulse;
    testChain;
    print_verdict;
  end
endmodule // triple_timer_counter_unit_bench
